/* File: design/nlsw_map.vh */
// Register map and field constants for the network link status word bank
`ifndef NLSW_MAP_VH
`define NLSW_MAP_VH

// Register indices (byte address is four times the index)
`define NLSW_IDX_LOCAL_PART 8'h5A
`define NLSW_IDX_NODE_12 8'h5B
`define NLSW_IDX_NODE_34 8'h5C
`define NLSW_IDX_NODE_56 8'h5D
`define NLSW_IDX_TERM 8'h5F
`define NLSW_IDX_ERR 8'hBE
`define NLSW_IDX_POLL_START 8'hBF
`define NLSW_IDX_MAP_LOW 8'hC0
`define NLSW_IDX_MAP_HIGH 8'hC1
`define NLSW_IDX_IRQ_STATUS 8'hD0
`define NLSW_IDX_IRQ_MASK 8'hD1

// Field positions
`define NLSW_BIT_LOCAL_PART 15
`define NLSW_BIT_TERM 11
`define NLSW_BIT_ERR_PARAM 0
`define NLSW_BIT_ERR_TABLE 1
`define NLSW_BIT_ERR_ROUTE 2
`define NLSW_BIT_ERR_NVMEM 7
`define NLSW_BIT_ERR_DUPNODE 9
`define NLSW_BIT_ERR_MISMATCH 10
`define NLSW_BIT_ERR_TXFAULT 11
`define NLSW_BIT_ERR_HWFAULT 12
`define NLSW_BIT_ERR_LOG 15

// Interrupt status bit positions
`define NLSW_IRQ_LINK_CHG 0
`define NLSW_IRQ_ERR_RISE 1
`define NLSW_IRQ_MAP_CHG 2
`define NLSW_IRQ_WIDTH 3

// Reset values
`define NLSW_RST_WORD 16'h0000
`define NLSW_RST_MASK 3'h0

// AHB encodings
`define NLSW_HTRANS_NONSEQ 2'h2
`define NLSW_HTRANS_SEQ 2'h3

`endif

/* File: design/nlsw_status_bank.v */
// Network link status word bank with AHB-Lite register slave
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps
`include "nlsw_map.vh"
module nlsw_status_bank #(
    parameter NODE_CNT = 6
) (
    // Clock, reset, enable
    input wire mclk_in,
    input wire rst_in,
    input wire clk_en_in,
    // AHB-Lite slave
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output wire [31:0] hrdata_out,
    output wire hreadyout_out,
    output wire hresp_out,
    // Board state
    input wire link_active_in,
    input wire [8*NODE_CNT-1:0] node_link_status_in,
    input wire term_switch_on_in,
    input wire err_param_in,
    input wire err_table_in,
    input wire err_route_in,
    input wire err_nvmem_in,
    input wire err_dupnode_in,
    input wire err_mismatch_in,
    input wire err_txfault_in,
    input wire err_hwfault_in,
    input wire err_log_nonempty_in,
    input wire [7:0] polling_node_in,
    input wire [7:0] startup_node_in,
    input wire [31:0] participation_map_in,
    // Interrupt
    output wire irq_out
);

// Bus states
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_READ = 3'b010;
localparam [2:0] ST_WRITE = 3'b100;
localparam integer WORD_CNT = NODE_CNT / 2;
localparam [2:0] SIZE_WORD = 3'h2;

// Captured status words
reg [15:0] local_part;
reg [15:0] node_word [0:WORD_CNT-1];
reg [15:0] term_word;
reg [15:0] err_word;
reg [15:0] poll_word;
reg [15:0] map_low;
reg [15:0] map_high;

// Interrupt state
reg [`NLSW_IRQ_WIDTH-1:0] irq_status;
reg [`NLSW_IRQ_WIDTH-1:0] irq_mask;
reg irq_q;

// Bus slave state
reg [2:0] bus_state;
reg [7:0] idx_q;
reg [31:0] rdata;

// Next values
reg [2:0] next_bus_state;
reg [15:0] next_local;
reg [15:0] next_term;
reg [15:0] next_err;
reg [15:0] next_poll;
reg [15:0] next_word;
reg [31:0] next_rdata;
reg [`NLSW_IRQ_WIDTH-1:0] next_mask;
reg [`NLSW_IRQ_WIDTH-1:0] next_status;
reg [`NLSW_IRQ_WIDTH-1:0] events;
reg [`NLSW_IRQ_WIDTH-1:0] rd_clear;

// Bus decode
wire take;
wire take_read;
wire take_write;
wire [7:0] idx;
wire rd_phase;
wire wr_phase;
wire mask_hit;
wire status_hit;

assign take = hsel_in && hready_in && htrans_in[1];
assign take_read = take && !hwrite_in;
assign take_write = take && hwrite_in && (hsize_in == SIZE_WORD);
assign idx = haddr_in[9:2];
assign rd_phase = (bus_state == ST_READ);
assign wr_phase = (bus_state == ST_WRITE);
assign mask_hit = (idx_q == `NLSW_IDX_IRQ_MASK);
assign status_hit = (idx_q == `NLSW_IDX_IRQ_STATUS);

// Bus state machine; a new transfer may be taken in any state
always @* begin
    next_bus_state = bus_state;
    case (bus_state)
        ST_IDLE: begin
            if (take_read) begin
                next_bus_state = ST_READ;
            end else if (take_write) begin
                next_bus_state = ST_WRITE;
            end
        end
        ST_READ: begin
            if (take_read) begin
                next_bus_state = ST_READ;
            end else if (take_write) begin
                next_bus_state = ST_WRITE;
            end else if (hready_in) begin
                next_bus_state = ST_IDLE;
            end
        end
        ST_WRITE: begin
            if (take_read) begin
                next_bus_state = ST_READ;
            end else if (take_write) begin
                next_bus_state = ST_WRITE;
            end else if (hready_in) begin
                next_bus_state = ST_IDLE;
            end
        end
        default: begin
            next_bus_state = ST_IDLE;
        end
    endcase
end

// Status word next values
always @* begin
    next_local = `NLSW_RST_WORD;
    next_local[`NLSW_BIT_LOCAL_PART] = link_active_in;
end

always @* begin
    next_term = `NLSW_RST_WORD;
    next_term[`NLSW_BIT_TERM] = term_switch_on_in;
end

always @* begin
    next_err = `NLSW_RST_WORD;
    next_err[`NLSW_BIT_ERR_PARAM] = err_param_in;
    next_err[`NLSW_BIT_ERR_TABLE] = err_table_in;
    next_err[`NLSW_BIT_ERR_ROUTE] = err_route_in;
    next_err[`NLSW_BIT_ERR_NVMEM] = err_nvmem_in;
    next_err[`NLSW_BIT_ERR_DUPNODE] = err_dupnode_in;
    next_err[`NLSW_BIT_ERR_MISMATCH] = err_mismatch_in;
    next_err[`NLSW_BIT_ERR_TXFAULT] = err_txfault_in;
    next_err[`NLSW_BIT_ERR_HWFAULT] = err_hwfault_in;
    next_err[`NLSW_BIT_ERR_LOG] = err_log_nonempty_in;
end

always @* begin
    next_poll = `NLSW_RST_WORD;
    next_poll[7:0] = polling_node_in;
    next_poll[15:8] = startup_node_in;
end

// Interrupt events: link change, any error rising, map change
always @* begin
    events = {`NLSW_IRQ_WIDTH{1'b0}};
    events[`NLSW_IRQ_LINK_CHG] = local_part[`NLSW_BIT_LOCAL_PART] != link_active_in;
    events[`NLSW_IRQ_ERR_RISE] = |(next_err & ~err_word);
    events[`NLSW_IRQ_MAP_CHG] = {map_high, map_low} != participation_map_in;
end

// Only the bits handed to the reader are cleared
always @* begin
    rd_clear = {`NLSW_IRQ_WIDTH{1'b0}};
    if (rd_phase && status_hit) begin
        rd_clear = rdata[`NLSW_IRQ_WIDTH-1:0];
    end
end

// New events win over the read clear
always @* begin
    next_status = (irq_status & ~rd_clear) | events;
end

// Writes only reach the mask; status words ignore them
always @* begin
    next_mask = irq_mask;
    if (wr_phase && mask_hit) begin
        next_mask = hwdata_in[`NLSW_IRQ_WIDTH-1:0];
    end
end

// Read word chosen in the address phase; mask and status forwarded
always @* begin
    next_word = `NLSW_RST_WORD;
    case (idx)
        `NLSW_IDX_LOCAL_PART: begin
            next_word = local_part;
        end
        `NLSW_IDX_NODE_12: begin
            next_word = node_word[0];
        end
        `NLSW_IDX_NODE_34: begin
            next_word = node_word[1];
        end
        `NLSW_IDX_NODE_56: begin
            next_word = node_word[2];
        end
        `NLSW_IDX_TERM: begin
            next_word = term_word;
        end
        `NLSW_IDX_ERR: begin
            next_word = err_word;
        end
        `NLSW_IDX_POLL_START: begin
            next_word = poll_word;
        end
        `NLSW_IDX_MAP_LOW: begin
            next_word = map_low;
        end
        `NLSW_IDX_MAP_HIGH: begin
            next_word = map_high;
        end
        `NLSW_IDX_IRQ_STATUS: begin
            next_word = {13'h0000, next_status};
        end
        `NLSW_IDX_IRQ_MASK: begin
            next_word = {13'h0000, next_mask};
        end
        default: begin
            next_word = `NLSW_RST_WORD;
        end
    endcase
end

always @* begin
    next_rdata = {16'h0000, next_word};
end

// Status word capture, one word per pair of nodes
genvar g;
generate
    for (g = 0; g < WORD_CNT; g = g + 1) begin : g_node
        always @(posedge mclk_in or posedge rst_in) begin
            if (rst_in) begin
                node_word[g] <= `NLSW_RST_WORD;
            end else if (clk_en_in) begin
                node_word[g] <= node_link_status_in[16*g+15:16*g];
            end
        end
    end
endgenerate

always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        local_part <= `NLSW_RST_WORD;
    end else if (clk_en_in) begin
        local_part <= next_local;
    end
end

always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        term_word <= `NLSW_RST_WORD;
    end else if (clk_en_in) begin
        term_word <= next_term;
    end
end

always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        err_word <= `NLSW_RST_WORD;
    end else if (clk_en_in) begin
        err_word <= next_err;
    end
end

always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        poll_word <= `NLSW_RST_WORD;
    end else if (clk_en_in) begin
        poll_word <= next_poll;
    end
end

always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        map_low <= `NLSW_RST_WORD;
    end else if (clk_en_in) begin
        map_low <= participation_map_in[15:0];
    end
end

always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        map_high <= `NLSW_RST_WORD;
    end else if (clk_en_in) begin
        map_high <= participation_map_in[31:16];
    end
end

// Bus slave registers
always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        bus_state <= ST_IDLE;
    end else if (clk_en_in) begin
        bus_state <= next_bus_state;
    end
end

always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        idx_q <= 8'h00;
    end else if (clk_en_in) begin
        if (take) begin
            idx_q <= idx;
        end
    end
end

// Read data held after its data phase
always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        rdata <= 32'h00000000;
    end else if (clk_en_in) begin
        if (take_read) begin
            rdata <= next_rdata;
        end
    end
end

// Interrupt registers
always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        irq_status <= `NLSW_RST_MASK;
    end else if (clk_en_in) begin
        irq_status <= next_status;
    end
end

always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        irq_mask <= `NLSW_RST_MASK;
    end else if (clk_en_in) begin
        irq_mask <= next_mask;
    end
end

always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        irq_q <= 1'b0;
    end else if (clk_en_in) begin
        irq_q <= |(next_status & next_mask);
    end
end

// Outputs; a frozen slave stalls the bus
assign hrdata_out = rdata;
assign hreadyout_out = clk_en_in;
assign hresp_out = 1'b0;
assign irq_out = irq_q;

endmodule

/* File: verification/nlsw_sva.sv */
// Port assertions for the status word bank
`timescale 1ns/100ps
module nlsw_sva #(
    parameter NODE_CNT = 6
) (
    // Clock, reset, bus
    input wire mclk_in, input wire rst_in, input wire clk_en_in, input wire hsel_in, input wire [31:0] haddr_in,
    input wire [1:0] htrans_in, input wire hwrite_in, input wire hready_in, input wire [31:0] hrdata_out,
    input wire hreadyout_out, input wire hresp_out,
    // Board state
    input wire link_active_in, input wire [8*NODE_CNT-1:0] node_link_status_in, input wire term_switch_on_in,
    input wire err_param_in, input wire err_table_in, input wire err_route_in, input wire err_nvmem_in,
    input wire err_dupnode_in, input wire err_mismatch_in, input wire err_txfault_in, input wire err_hwfault_in,
    input wire err_log_nonempty_in, input wire [7:0] polling_node_in, input wire [7:0] startup_node_in,
    input wire [31:0] participation_map_in
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    wire [8:0] ix = {hsel_in & hready_in & htrans_in[1] & ~hwrite_in, haddr_in[9:2]};
    property p_part; ix == 9'h15A ##1 1'b1 |-> hrdata_out == {$past(link_active_in, 2), 15'h0000}; endproperty
    a_part: assert property (p_part) else $error("part");
    property p_n12; ix == 9'h15B ##1 1'b1 |-> hrdata_out == $past(node_link_status_in[15:0], 2); endproperty
    a_n12: assert property (p_n12) else $error("n12");
    property p_n34; ix == 9'h15C ##1 1'b1 |-> hrdata_out == $past(node_link_status_in[31:16], 2); endproperty
    a_n34: assert property (p_n34) else $error("n34");
    property p_n56; ix == 9'h15D ##1 1'b1 |-> hrdata_out == $past(node_link_status_in[47:32], 2); endproperty
    a_n56: assert property (p_n56) else $error("n56");
    property p_gap; ix == 9'h15E ##1 1'b1 |-> hrdata_out == 32'h0; endproperty
    a_gap: assert property (p_gap) else $error("gap");
    property p_term; ix == 9'h15F ##1 1'b1 |-> hrdata_out == {$past(term_switch_on_in, 2), 11'h000}; endproperty
    a_term: assert property (p_term) else $error("term");
    property p_mlo; ix == 9'h1C0 ##1 1'b1 |-> hrdata_out == $past(participation_map_in[15:0], 2); endproperty
    a_mlo: assert property (p_mlo) else $error("mlo");
    property p_mhi; ix == 9'h1C1 ##1 1'b1 |-> hrdata_out == $past(participation_map_in[31:16], 2); endproperty
    a_mhi: assert property (p_mhi) else $error("mhi");
    property p_err; ix == 9'h1BE ##1 1'b1 |-> hrdata_out == {$past(err_log_nonempty_in, 2), 2'h0,
        $past(err_hwfault_in, 2), $past(err_txfault_in, 2), $past(err_mismatch_in, 2), $past(err_dupnode_in, 2),
        1'b0, $past(err_nvmem_in, 2), 4'h0, $past(err_route_in, 2), $past(err_table_in, 2), $past(err_param_in, 2)};
    endproperty
    a_err: assert property (p_err) else $error("err");
    property p_poll; ix == 9'h1BF ##1 1'b1 |-> hrdata_out == {$past(startup_node_in, 2), $past(polling_node_in, 2)};
    endproperty
    a_poll: assert property (p_poll) else $error("poll");
    property p_resp; hresp_out == 1'b0 && hreadyout_out == clk_en_in; endproperty
    a_resp: assert property (p_resp) else $error("resp");
endmodule
bind nlsw_status_bank nlsw_sva #(.NODE_CNT(NODE_CNT)) i_sva (.mclk_in(mclk_in), .rst_in(rst_in),
    .clk_en_in(clk_en_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .link_active_in(link_active_in), .node_link_status_in(node_link_status_in),
    .term_switch_on_in(term_switch_on_in), .err_param_in(err_param_in), .err_table_in(err_table_in),
    .err_route_in(err_route_in), .err_nvmem_in(err_nvmem_in), .err_dupnode_in(err_dupnode_in),
    .err_mismatch_in(err_mismatch_in), .err_txfault_in(err_txfault_in), .err_hwfault_in(err_hwfault_in),
    .err_log_nonempty_in(err_log_nonempty_in), .polling_node_in(polling_node_in),
    .startup_node_in(startup_node_in), .participation_map_in(participation_map_in));

/* File: verification/nlsw_cpu.sv */
// CPU-side AHB-Lite master for single word transfers
`timescale 1ns/100ps
module nlsw_cpu (
    // Clock and slave answer
    input wire mclk_in, input wire hready_in, input wire [31:0] hrdata_in,
    // Master side
    output reg [1:0] htrans_out = 2'h0, output reg [31:0] haddr_out = 32'h0,
    output reg hwrite_out = 1'b0, output reg [31:0] hwdata_out = 32'h0
);
    integer n;
    // Each phase held until hready; a stuck slave returns unknown data
    task xfer(input [7:0] ix, input wr, input [31:0] wd, output [31:0] rd);
        @(posedge mclk_in);
        htrans_out <= 2'h2;
        haddr_out <= {22'h0, ix, 2'h0};
        hwrite_out <= wr;
        n = 0;
        do @(posedge mclk_in); while (!hready_in && ++n < 16);
        htrans_out <= 2'h0;
        hwdata_out <= wd;
        do @(posedge mclk_in); while (!hready_in && ++n < 16);
        rd = (n < 16) ? hrdata_in : 32'hX;
    endtask
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the status word bank
`timescale 1ns/100ps
module tb_top;
    reg mclk_in = 1'b0, rst_in = 1'b1, link = 1'b0, term = 1'b0;
    reg [8:0] errs = 9'h000;
    reg [15:0] pn = 16'h0000;
    reg [47:0] nodes = 48'h0;
    reg [31:0] pmap = 32'h0, r, rd;
    wire [1:0] htrans;
    wire [31:0] haddr, hwdata, hrdata;
    wire hwrite, hready, irq;
    integer err_count = 0, checked = 0, k, i;
    reg [7:0] idx [0:9] = '{8'h5A, 8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h5F, 8'hBE, 8'hBF, 8'hC0, 8'hC1};
    wire [15:0] errw = {errs[8], 2'h0, errs[7:4], 1'b0, errs[3], 4'h0, errs[2:0]};
    wire [159:0] expv = {pmap, pn, errw, 4'h0, term, 11'h000, 16'h0000, nodes, link, 15'h0000};
    nlsw_status_bank i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .clk_en_in(1'b1), .hsel_in(1'b1),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(), .link_active_in(link),
        .node_link_status_in(nodes), .term_switch_on_in(term), .err_param_in(errs[0]), .err_table_in(errs[1]),
        .err_route_in(errs[2]), .err_nvmem_in(errs[3]), .err_dupnode_in(errs[4]), .err_mismatch_in(errs[5]),
        .err_txfault_in(errs[6]), .err_hwfault_in(errs[7]), .err_log_nonempty_in(errs[8]),
        .polling_node_in(pn[7:0]), .startup_node_in(pn[15:8]), .participation_map_in(pmap), .irq_out(irq));
    nlsw_cpu i_cpu (.mclk_in(mclk_in), .hready_in(hready), .hrdata_in(hrdata), .htrans_out(htrans),
        .haddr_out(haddr), .hwrite_out(hwrite), .hwdata_out(hwdata));
    initial forever #2.5 mclk_in = ~mclk_in;
    task chk(input [31:0] exp, input [31:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task rdchk(input [7:0] ix, input [15:0] e);
        i_cpu.xfer(ix, 1'b0, 32'h0, rd);
        chk({16'h0000, e}, rd);
        if (i_cpu.n >= 16) conclude;
    endtask
    task wait_irq(input v);
        for (i = 0; i < 8 && irq !== v; i = i + 1)
            @(negedge mclk_in);
        chk({31'h0, v}, {31'h0, irq});
        if (i == 8) conclude;
    endtask
    task conclude;
        $display("checked=%0d mismatches=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        r = $urandom(32'h1701);
        repeat (5) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (k = 0; k < 20; k = k + 1) begin
            {nodes[47:16], pmap} <= {$urandom, $urandom};
            {nodes[15:0], pn} <= $urandom;
            {r[20:0], link, term, errs} <= $urandom;
            i_cpu.xfer(idx[k % 10], 1'b1, 32'hFFFF, rd);
            for (i = 0; i < 10; i = i + 1)
                rdchk(idx[i], expv[16*i +: 16]);
        end
        $display("test status words done");
        i_cpu.xfer(8'hD0, 1'b0, 32'h0, rd);
        link <= ~link;
        repeat (4) @(posedge mclk_in);
        @(negedge mclk_in);
        chk(32'h0, {31'h0, irq});
        rdchk(8'hD0, 16'h0001);
        rdchk(8'hD0, 16'h0000);
        errs <= 9'h000;
        pmap <= ~pmap;
        repeat (3) @(posedge mclk_in);
        rdchk(8'hD0, 16'h0004);
        errs <= 9'h1FF;
        repeat (3) @(posedge mclk_in);
        rdchk(8'hD0, 16'h0002);
        i_cpu.xfer(8'hD1, 1'b1, 32'h7, rd);
        rdchk(8'hD1, 16'h0007);
        link <= ~link;
        wait_irq(1'b1);
        rdchk(8'hD0, 16'h0001);
        wait_irq(1'b0);
        $display("test interrupt done");
        conclude;
    end
endmodule
